// *** shared/clkmux_consts.svh ***
`ifndef CLKMUX_CONSTS_SVH
`define CLKMUX_CONSTS_SVH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define USB_SOURCE_SELECT_ADDR 32'h400480C0
`define USB_SOURCE_UPDATE_ADDR 32'h400480C4
`define USB_CLOCK_DIVIDER_ADDR 32'h400480C8
`define OUT_SOURCE_SELECT_ADDR 32'h400480E0
`define OUT_SOURCE_UPDATE_ADDR 32'h400480E4
`define OUT_PIN_DIVIDER_ADDR 32'h400480E8
`define SWITCH_STATUS_ADDR 32'h400480F0

// ****************************************************************
// field positions
// ****************************************************************
`define SEL_MSB 1
`define DIV_MSB 7
`define UPDATE_BIT 0
`define ST_USB_BUSY 0
`define ST_USB_SRC_LSB 1
`define ST_OUT_BUSY 4
`define ST_OUT_SRC_LSB 5

// ****************************************************************
// reset values
// ****************************************************************
`define USB_SEL_RST 2'h0
`define USB_DIV_RST 8'h01
`define OUT_SEL_RST 2'h0
`define OUT_DIV_RST 8'h00
`define UPDATE_RST 1'h0

`endif

// *** shared/clkmux_pkg.sv ***
`default_nettype none

package clkmux_pkg;

    typedef enum logic [1:0] {SW_IDLE, SW_DRAIN_OLD, SW_WAIT_NEW}
        switch_state_t;

    typedef enum logic [1:0] {USB_SRC_PLL, USB_SRC_MAIN, USB_SRC_RSV2,
        USB_SRC_RSV3} usb_src_t;

    typedef enum logic [1:0] {OUT_SRC_RC, OUT_SRC_XTAL, OUT_SRC_LFO,
        OUT_SRC_MAIN} out_src_t;

endpackage

`default_nettype wire

// *** hdl/clock_divider.sv ***
`default_nettype none

module clock_divider #(
    parameter int DIV_WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic src_i,
    input wire logic [DIV_WIDTH-1:0] div_i,
    output logic clk_o
);

    // ****************************************************************
    // parameter check
    // ****************************************************************
    if (DIV_WIDTH < 2 || DIV_WIDTH > 16)
    begin : g_bad_width
        $error("clock_divider: DIV_WIDTH out of range");
    end

    logic src_reg;
    logic [DIV_WIDTH-1:0] cnt_reg;
    logic [DIV_WIDTH-1:0] cnt_next;
    logic [DIV_WIDTH-1:0] half;
    logic out_reg;
    logic rise;

    assign rise = src_i & ~src_reg;
    assign half = DIV_WIDTH'(({1'b0, div_i} + (DIV_WIDTH+1)'(1)) >> 1);
    assign clk_o = out_reg;

    // ****************************************************************
    // source edge tracking
    // ****************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            src_reg <= 1'b0;
        else
            src_reg <= src_i;
    end

    always_comb
    begin
        if (cnt_reg >= div_i - DIV_WIDTH'(1))
            cnt_next = '0;
        else
            cnt_next = cnt_reg + DIV_WIDTH'(1);
    end

    // ****************************************************************
    // divide by n, zero stops
    // ****************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            cnt_reg <= '0;
            out_reg <= 1'b0;
        end
        else if (div_i == '0)
        begin
            cnt_reg <= '0;
            out_reg <= 1'b0;
        end
        else if (div_i == DIV_WIDTH'(1))
        begin
            cnt_reg <= '0;
            out_reg <= src_i;
        end
        else if (rise)
        begin
            cnt_reg <= cnt_next;
            out_reg <= (cnt_next < half);
        end
    end

endmodule

`default_nettype wire

// *** hdl/clock_mux_top.sv ***
// What this block does
// - usb source code 0 picks usb pll, 1 main clock, 2 and 3 reserved
// - usb selector change waits for a zero-to-one edge on its update bit
// - usb update register: bit 0, resets zero, one requests the update
// - after reset the usb clock comes from the usb pll
// - usb divider eight bits, zero stops, n divides by n, resets to one
// - pin source 0 rc, 1 crystal, 2 low-frequency, 3 main; resets rc
// - pin selector change waits for a zero-to-one edge on its bit 0
// - pin update register: bit 0, resets zero, one requests the update
// - pin divider eight bits, resets zero, zero disables, n divides by n
`include "clkmux_consts.svh"
`default_nettype none

module clock_mux_top
    import clkmux_pkg::*;
#(
    parameter int DIV_WIDTH = 8
) (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic [31:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    input wire logic USB_PLL_CLK_I,
    input wire logic MAIN_CLK_I,
    input wire logic RC_OSC_CLK_I,
    input wire logic XTAL_CLK_I,
    input wire logic LFO_CLK_I,
    output logic USB_CLK_O,
    output logic CLOCK_OUTPUT_PIN_O
);

    // ****************************************************************
    // parameter check
    // ****************************************************************
    if (DIV_WIDTH != 8)
    begin : g_bad_width
        $error("clock_mux_top: register layout needs DIV_WIDTH of 8");
    end

    // ****************************************************************
    // helper functions
    // ****************************************************************
    function automatic logic hit(input logic [31:0] addr,
                                 input logic [31:0] target);
        hit = (addr == target);
    endfunction

    function automatic logic usb_pick(input logic [1:0] sel,
                                      input logic pll,
                                      input logic main_clk);
        case (sel)
            USB_SRC_PLL: usb_pick = pll;
            USB_SRC_MAIN: usb_pick = main_clk;
            default: usb_pick = 1'b0;
        endcase
    endfunction

    function automatic logic out_pick(input logic [1:0] sel,
                                      input logic [3:0] srcs);
        case (sel)
            OUT_SRC_RC: out_pick = srcs[0];
            OUT_SRC_XTAL: out_pick = srcs[1];
            OUT_SRC_LFO: out_pick = srcs[2];
            OUT_SRC_MAIN: out_pick = srcs[3];
            default: out_pick = 1'b0;
        endcase
    endfunction

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic [1:0] usb_source_select_reg;
    logic usb_source_update_reg;
    logic [7:0] usb_clock_divider_reg;
    logic [1:0] output_pin_source_select_reg;
    logic output_pin_source_update_reg;
    logic [7:0] output_pin_divider_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic usb_req;
    logic out_req;
    logic usb_pend_reg;
    logic out_pend_reg;
    switch_state_t usb_state_reg;
    switch_state_t out_state_reg;
    logic [1:0] usb_applied_reg;
    logic [1:0] usb_target_reg;
    logic usb_gate_reg;
    logic [1:0] out_applied_reg;
    logic [1:0] out_target_reg;
    logic out_gate_reg;
    logic [3:0] out_srcs;
    logic usb_cur;
    logic usb_gated;
    logic out_cur;
    logic out_gated;

    assign out_srcs = {MAIN_CLK_I, LFO_CLK_I, XTAL_CLK_I, RC_OSC_CLK_I};
    assign RDATA_O = rdata_reg;

    // ****************************************************************
    // update edge detection
    // ****************************************************************
    assign usb_req = WR_I && hit(ADDR_I, `USB_SOURCE_UPDATE_ADDR)
                     && WDATA_I[`UPDATE_BIT] && !usb_source_update_reg;
    assign out_req = WR_I && hit(ADDR_I, `OUT_SOURCE_UPDATE_ADDR)
                     && WDATA_I[`UPDATE_BIT]
                     && !output_pin_source_update_reg;

    // ****************************************************************
    // usb registers
    // ****************************************************************
    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
            usb_source_select_reg <= `USB_SEL_RST;
        else if (WR_I && hit(ADDR_I, `USB_SOURCE_SELECT_ADDR))
            usb_source_select_reg <= WDATA_I[`SEL_MSB:0];
    end

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
            usb_source_update_reg <= `UPDATE_RST;
        else if (WR_I && hit(ADDR_I, `USB_SOURCE_UPDATE_ADDR))
            usb_source_update_reg <= WDATA_I[`UPDATE_BIT];
    end

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
            usb_clock_divider_reg <= `USB_DIV_RST;
        else if (WR_I && hit(ADDR_I, `USB_CLOCK_DIVIDER_ADDR))
            usb_clock_divider_reg <= WDATA_I[`DIV_MSB:0];
    end

    // ****************************************************************
    // pin registers
    // ****************************************************************
    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
            output_pin_source_select_reg <= `OUT_SEL_RST;
        else if (WR_I && hit(ADDR_I, `OUT_SOURCE_SELECT_ADDR))
            output_pin_source_select_reg <= WDATA_I[`SEL_MSB:0];
    end

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
            output_pin_source_update_reg <= `UPDATE_RST;
        else if (WR_I && hit(ADDR_I, `OUT_SOURCE_UPDATE_ADDR))
            output_pin_source_update_reg <= WDATA_I[`UPDATE_BIT];
    end

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
            output_pin_divider_reg <= `OUT_DIV_RST;
        else if (WR_I && hit(ADDR_I, `OUT_PIN_DIVIDER_ADDR))
            output_pin_divider_reg <= WDATA_I[`DIV_MSB:0];
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    always_comb
    begin
        rdata_next = 32'h00000000;
        if (hit(ADDR_I, `USB_SOURCE_SELECT_ADDR))
            rdata_next[`SEL_MSB:0] = usb_source_select_reg;
        else if (hit(ADDR_I, `USB_SOURCE_UPDATE_ADDR))
            rdata_next[`UPDATE_BIT] = usb_source_update_reg;
        else if (hit(ADDR_I, `USB_CLOCK_DIVIDER_ADDR))
            rdata_next[`DIV_MSB:0] = usb_clock_divider_reg;
        else if (hit(ADDR_I, `OUT_SOURCE_SELECT_ADDR))
            rdata_next[`SEL_MSB:0] = output_pin_source_select_reg;
        else if (hit(ADDR_I, `OUT_SOURCE_UPDATE_ADDR))
            rdata_next[`UPDATE_BIT] = output_pin_source_update_reg;
        else if (hit(ADDR_I, `OUT_PIN_DIVIDER_ADDR))
            rdata_next[`DIV_MSB:0] = output_pin_divider_reg;
        else if (hit(ADDR_I, `SWITCH_STATUS_ADDR))
        begin
            rdata_next[`ST_USB_BUSY] = (usb_state_reg != SW_IDLE)
                                       || usb_pend_reg;
            rdata_next[`ST_USB_SRC_LSB+1:`ST_USB_SRC_LSB] = usb_applied_reg;
            rdata_next[`ST_OUT_BUSY] = (out_state_reg != SW_IDLE)
                                       || out_pend_reg;
            rdata_next[`ST_OUT_SRC_LSB+1:`ST_OUT_SRC_LSB] = out_applied_reg;
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
            rdata_reg <= 32'h00000000;
        else if (RD_I)
            rdata_reg <= rdata_next;
        else
            rdata_reg <= 32'h00000000;
    end

    // ****************************************************************
    // pending update requests
    // ****************************************************************
    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
            usb_pend_reg <= 1'b0;
        else if (usb_req)
            usb_pend_reg <= 1'b1;
        else if (usb_state_reg == SW_IDLE)
            usb_pend_reg <= 1'b0;
    end

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
            out_pend_reg <= 1'b0;
        else if (out_req)
            out_pend_reg <= 1'b1;
        else if (out_state_reg == SW_IDLE)
            out_pend_reg <= 1'b0;
    end

    // ****************************************************************
    // usb glitch-free switch
    // ****************************************************************
    assign usb_cur = usb_pick(usb_applied_reg, USB_PLL_CLK_I, MAIN_CLK_I);
    assign usb_gated = usb_gate_reg & usb_cur;

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            usb_state_reg <= SW_IDLE;
            usb_applied_reg <= `USB_SEL_RST;
            usb_target_reg <= `USB_SEL_RST;
            usb_gate_reg <= 1'b1;
        end
        else
        begin
            case (usb_state_reg)
                SW_IDLE:
                begin
                    if (usb_pend_reg && usb_source_select_reg[1] == 1'b0
                        && usb_source_select_reg != usb_applied_reg)
                    begin
                        usb_target_reg <= usb_source_select_reg;
                        usb_state_reg <= SW_DRAIN_OLD;
                    end
                end
                SW_DRAIN_OLD:
                begin
                    if (!usb_cur)
                    begin
                        usb_gate_reg <= 1'b0;
                        usb_applied_reg <= usb_target_reg;
                        usb_state_reg <= SW_WAIT_NEW;
                    end
                end
                SW_WAIT_NEW:
                begin
                    if (!usb_cur)
                    begin
                        usb_gate_reg <= 1'b1;
                        usb_state_reg <= SW_IDLE;
                    end
                end
                default:
                    usb_state_reg <= SW_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // pin glitch-free switch
    // ****************************************************************
    assign out_cur = out_pick(out_applied_reg, out_srcs);
    assign out_gated = out_gate_reg & out_cur;

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            out_state_reg <= SW_IDLE;
            out_applied_reg <= `OUT_SEL_RST;
            out_target_reg <= `OUT_SEL_RST;
            out_gate_reg <= 1'b1;
        end
        else
        begin
            case (out_state_reg)
                SW_IDLE:
                begin
                    if (out_pend_reg
                        && output_pin_source_select_reg != out_applied_reg)
                    begin
                        out_target_reg <= output_pin_source_select_reg;
                        out_state_reg <= SW_DRAIN_OLD;
                    end
                end
                SW_DRAIN_OLD:
                begin
                    if (!out_cur)
                    begin
                        out_gate_reg <= 1'b0;
                        out_applied_reg <= out_target_reg;
                        out_state_reg <= SW_WAIT_NEW;
                    end
                end
                SW_WAIT_NEW:
                begin
                    if (!out_cur)
                    begin
                        out_gate_reg <= 1'b1;
                        out_state_reg <= SW_IDLE;
                    end
                end
                default:
                    out_state_reg <= SW_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // dividers
    // ****************************************************************
    clock_divider #(
        .DIV_WIDTH(DIV_WIDTH)
    ) u_usb_div (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .src_i(usb_gated),
        .div_i(usb_clock_divider_reg),
        .clk_o(USB_CLK_O)
    );

    clock_divider #(
        .DIV_WIDTH(DIV_WIDTH)
    ) u_out_div (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .src_i(out_gated),
        .div_i(output_pin_divider_reg),
        .clk_o(CLOCK_OUTPUT_PIN_O)
    );

endmodule

`default_nettype wire

// *** dv/clock_sources_model.sv ***
`default_nettype none

module clock_sources_model #(
    parameter int PLL_HALF = 2,
    parameter int MAIN_HALF = 3,
    parameter int RC_HALF = 2,
    parameter int XTAL_HALF = 4,
    parameter int LFO_HALF = 5
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic pll_on_i,
    output logic pll_clk_o,
    output logic main_clk_o,
    output logic rc_clk_o,
    output logic xtal_clk_o,
    output logic lfo_clk_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] cnt_reg;

    // sources other than the gated pll free running, synchronous to the system clock
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            cnt_reg <= 32'h0;
        else
            cnt_reg <= cnt_reg + 32'h1;
    end

    // pll stops low once the bench powers it down
    assign pll_clk_o = pll_on_i && (cnt_reg / PLL_HALF) % 2 == 1;
    // main clock stands in for the fixed usb rate
    assign main_clk_o = (cnt_reg / MAIN_HALF) % 2 == 1;
    assign rc_clk_o = (cnt_reg / RC_HALF) % 2 == 1;
    assign xtal_clk_o = (cnt_reg / XTAL_HALF) % 2 == 1;
    assign lfo_clk_o = (cnt_reg / LFO_HALF) % 2 == 1;
endmodule

`default_nettype wire

// *** dv/clock_mux_checker.sv ***
`include "clkmux_consts.svh"
`default_nettype none

module clock_mux_checker
    import clkmux_pkg::*;
#(
    parameter int DIV_WIDTH = 8
) (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic [31:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [31:0] RDATA_O,
    input wire logic USB_PLL_CLK_I,
    input wire logic MAIN_CLK_I,
    input wire logic RC_OSC_CLK_I,
    input wire logic XTAL_CLK_I,
    input wire logic LFO_CLK_I,
    input wire logic USB_CLK_O,
    input wire logic CLOCK_OUTPUT_PIN_O
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] usb_div_reg;
    logic [7:0] pin_div_reg;
    logic usb_upd_reg;
    logic pin_upd_reg;
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!NRST_I);

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            usb_div_reg <= 8'h01;
            pin_div_reg <= 8'h00;
        end
        else if (WR_I && ADDR_I == `USB_CLOCK_DIVIDER_ADDR)
            usb_div_reg <= WDATA_I[7:0];
        else if (WR_I && ADDR_I == `OUT_PIN_DIVIDER_ADDR)
            pin_div_reg <= WDATA_I[7:0];
    end

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            usb_upd_reg <= 1'b0;
            pin_upd_reg <= 1'b0;
        end
        else if (WR_I && WDATA_I[0])
        begin
            usb_upd_reg <= usb_upd_reg | (ADDR_I == `USB_SOURCE_UPDATE_ADDR);
            pin_upd_reg <= pin_upd_reg | (ADDR_I == `OUT_SOURCE_UPDATE_ADDR);
        end
    end

    property p_usb_sel_rsvd;
        RD_I && ADDR_I == `USB_SOURCE_SELECT_ADDR |=> RDATA_O[31:2] == 30'h0;
    endproperty
    a_usb_sel_rsvd: assert property (p_usb_sel_rsvd)
        else $error("usb select reserved bits set");
    property p_pin_sel_rsvd;
        RD_I && ADDR_I == `OUT_SOURCE_SELECT_ADDR ##1 RDATA_O[31:2] != 30'h0
            |-> 1'b0;
    endproperty
    a_pin_sel_rsvd: assert property (p_pin_sel_rsvd)
        else $error("pin select reserved bits set");
    property p_upd_rsvd;
        RD_I && (ADDR_I == `USB_SOURCE_UPDATE_ADDR ||
            ADDR_I == `OUT_SOURCE_UPDATE_ADDR) |=> RDATA_O[31:1] == 31'h0;
    endproperty
    a_upd_rsvd: assert property (p_upd_rsvd)
        else $error("update reserved bits set");
    property p_div_rsvd;
        RD_I && (ADDR_I == `USB_CLOCK_DIVIDER_ADDR ||
            ADDR_I == `OUT_PIN_DIVIDER_ADDR) |=> RDATA_O[31:8] == 24'h0;
    endproperty
    a_div_rsvd: assert property (p_div_rsvd)
        else $error("divider reserved bits set");
    property p_usb_stop;
        usb_div_reg == 8'h00 |=> !USB_CLK_O;
    endproperty
    a_usb_stop: assert property (p_usb_stop)
        else $error("usb clock runs with divider zero");
    property p_pin_stop;
        pin_div_reg == 8'h00 [*2] |-> !CLOCK_OUTPUT_PIN_O;
    endproperty
    a_pin_stop: assert property (p_pin_stop)
        else $error("pin clock runs with divider zero");
    property p_usb_keep;
        usb_div_reg == 8'h01 && !usb_upd_reg |=>
            USB_CLK_O == $past(USB_PLL_CLK_I);
    endproperty
    a_usb_keep: assert property (p_usb_keep)
        else $error("usb clock left pll before update");
    property p_pin_keep;
        pin_div_reg == 8'h01 && !pin_upd_reg |=>
            CLOCK_OUTPUT_PIN_O == $past(RC_OSC_CLK_I);
    endproperty
    a_pin_keep: assert property (p_pin_keep)
        else $error("pin clock left rc before update");
    property p_pin_runt;
        $rose(CLOCK_OUTPUT_PIN_O) && pin_div_reg == 8'h01 &&
            $past(pin_div_reg) == 8'h01 && $past(pin_div_reg, 2) == 8'h01
            |=> CLOCK_OUTPUT_PIN_O;
    endproperty
    a_pin_runt: assert property (p_pin_runt)
        else $error("pin clock high pulse too short");
    property p_usb_runt;
        $fell(USB_CLK_O) && usb_div_reg == 8'h01 &&
            $past(usb_div_reg) == 8'h01 && $past(usb_div_reg, 2) == 8'h01
            |=> !USB_CLK_O;
    endproperty
    a_usb_runt: assert property (p_usb_runt)
        else $error("usb clock low pulse too short");
endmodule

bind clock_mux_top clock_mux_checker #(.DIV_WIDTH(DIV_WIDTH)) chk_u (
    .CLK_I, .NRST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O,
    .USB_PLL_CLK_I, .MAIN_CLK_I, .RC_OSC_CLK_I, .XTAL_CLK_I, .LFO_CLK_I,
    .USB_CLK_O, .CLOCK_OUTPUT_PIN_O
);

`default_nettype wire

// *** dv/tb_usb_and_clock_output_pin_clock_mux.sv ***
`include "clkmux_consts.svh"
`default_nettype none

module tb_usb_and_clock_output_pin_clock_mux;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic pll_on = 1'b1;
    logic [31:0] addr = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    wire pll, mainc, rcosc, xtal, lfo, usb_clk, pin_clk;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    int half [4] = '{2, 4, 5, 3};

    always #2 clk = ~clk;

    clock_sources_model src_u (.clk_i(clk), .nrst_i(nrst), .pll_on_i(pll_on),
        .pll_clk_o(pll), .main_clk_o(mainc), .rc_clk_o(rcosc),
        .xtal_clk_o(xtal), .lfo_clk_o(lfo));

    clock_mux_top #(.DIV_WIDTH(8)) dut_u (.CLK_I(clk), .NRST_I(nrst),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .USB_PLL_CLK_I(pll), .MAIN_CLK_I(mainc),
        .RC_OSC_CLK_I(rcosc), .XTAL_CLK_I(xtal), .LFO_CLK_I(lfo),
        .USB_CLK_O(usb_clk), .CLOCK_OUTPUT_PIN_O(pin_clk));

    task automatic end_of_test();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 12000)
        begin
            n_errors++;
            $display("Error %0t run too long", $time);
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr32(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd32(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic upd(input logic [31:0] a);
        wr32(a, 32'h0);
        wr32(a, 32'h1);
    endtask

    // count rising edges of one output over w cycles
    task automatic measure(input bit pin, input int w, input int exp_n,
        input string what);
        int n = 0;
        logic prev;
        logic cur;
        #1 prev = pin ? pin_clk : usb_clk;
        repeat (w)
        begin
            @(posedge clk);
            #1 cur = pin ? pin_clk : usb_clk;
            if (cur === 1'b1 && prev === 1'b0)
                n++;
            prev = cur;
        end
        chk(32'(n), 32'(exp_n), what);
    endtask

    task automatic t_regs();
        logic [31:0] a [7] = '{`USB_SOURCE_SELECT_ADDR,
            `USB_SOURCE_UPDATE_ADDR, `USB_CLOCK_DIVIDER_ADDR,
            `OUT_SOURCE_SELECT_ADDR, `OUT_SOURCE_UPDATE_ADDR,
            `OUT_PIN_DIVIDER_ADDR, 32'h400480CC};
        logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
        logic [31:0] wv [7] = '{32'hFFFFFFFF, 32'hFFFFFFFE, 32'hFFFFFFFF,
            32'hFFFFFFFF, 32'hFFFFFFFE, 32'hFFFFFFFF, 32'hFFFFFFFF};
        logic [31:0] ev [7] = '{32'h3, 32'h0, 32'hFF, 32'h3, 32'h0, 32'hFF,
            32'h0};
        logic [31:0] d;
        for (int i = 0; i < 7; i++)
        begin
            rd32(a[i], d);
            chk(d, rv[i], "reset");
            wr32(a[i], wv[i]);
            rd32(a[i], d);
            chk(d, ev[i], "mask");
            wr32(a[i], rv[i]);
        end
    endtask

    task automatic t_usb();
        measure(0, 120, 30, "usb pll rate");
        wr32(`USB_SOURCE_SELECT_ADDR, 32'h1);
        repeat (10) @(posedge clk);
        measure(0, 120, 30, "usb held");
        upd(`USB_SOURCE_UPDATE_ADDR);
        repeat (40) @(posedge clk);
        measure(0, 120, 20, "usb main");
        @(posedge clk);
        pll_on <= 1'b0;
        measure(0, 120, 20, "usb pll off");
        wr32(`USB_CLOCK_DIVIDER_ADDR, 32'h3);
        repeat (40) @(posedge clk);
        measure(0, 108, 6, "usb div 3");
        wr32(`USB_CLOCK_DIVIDER_ADDR, 32'h0);
        measure(0, 120, 0, "usb stopped");
        wr32(`USB_CLOCK_DIVIDER_ADDR, 32'h1);
        wr32(`USB_SOURCE_SELECT_ADDR, 32'h2);
        upd(`USB_SOURCE_UPDATE_ADDR);
        repeat (40) @(posedge clk);
        measure(0, 120, 20, "usb reserved code");
    endtask

    task automatic t_pin();
        int c;
        logic [31:0] d;
        measure(1, 120, 0, "pin off");
        wr32(`OUT_PIN_DIVIDER_ADDR, 32'h1);
        @(posedge clk);
        measure(1, 120, 30, "pin rc");
        for (int i = 0; i < 4; i++)
        begin
            c = (i + 1) % 4;
            wr32(`OUT_SOURCE_SELECT_ADDR, 32'(c));
            measure(1, 120, 60 / half[i], "pin held");
            upd(`OUT_SOURCE_UPDATE_ADDR);
            rd32(`SWITCH_STATUS_ADDR, d);
            chk(32'(d[`ST_OUT_BUSY]), 32'h1, "pin busy");
            repeat (40) @(posedge clk);
            rd32(`SWITCH_STATUS_ADDR, d);
            chk(d, 32'(c) << `ST_OUT_SRC_LSB | 32'h2, "status");
            measure(1, 120, 60 / half[c], "pin new");
        end
        wr32(`OUT_PIN_DIVIDER_ADDR, 32'hFF);
        repeat (1100) @(posedge clk);
        measure(1, 2040, 2, "pin div 255");
    endtask

    initial
    begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_usb();
        t_pin();
        end_of_test();
    end
endmodule

`default_nettype wire
